// File: ssp_pkg.sv
package ssp_pkg;
  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [11:0] ADDR_STATUS  = 12'h000;
  localparam logic [11:0] ADDR_RELOAD  = 12'h004;
  localparam logic [11:0] ADDR_MASK    = 12'h008;
  localparam logic [11:0] ADDR_CONTROL = 12'h00c;
  localparam logic [11:0] ADDR_RXDATA  = 12'h010;
  localparam logic [11:0] ADDR_TXDATA  = 12'h014;
  // ------------------------------------------------------------
  // status fields
  // ------------------------------------------------------------
  localparam int STAT_SAMPLE_BIT = 7;
  localparam int STAT_EDGE_BIT   = 6;
  localparam int STAT_FULL_BIT   = 0;
  // ------------------------------------------------------------
  // control fields
  // ------------------------------------------------------------
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_MODE_LSB   = 1;
  localparam int CTRL_MODE_W     = 2;
  localparam int CTRL_ADDR10_BIT = 3;
  localparam int CTRL_IDLE_BIT   = 4;
  // ------------------------------------------------------------
  // reset values, ten-bit header and synchroniser depth
  // ------------------------------------------------------------
  localparam logic [7:0] RST_STATUS  = 8'h00;
  localparam logic [7:0] RST_RELOAD  = 8'h00;
  localparam logic [7:0] RST_MASK    = 8'hff;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [4:0] TEN_BIT_HDR = 5'h1e;
  localparam int         SYNC_DEPTH  = 3;

  typedef enum logic [1:0] {
    SSP_SPI_MASTER = 2'b00,
    SSP_SPI_SLAVE  = 2'b01,
    SSP_I2C_MASTER = 2'b10,
    SSP_I2C_SLAVE  = 2'b11
  } ssp_mode_t;
endpackage : ssp_pkg

// File: ssp_buf2.sv
`timescale 1ns/100ps
module ssp_buf2 (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       in_valid,
  output logic            in_ready,
  input  wire logic [7:0] in_data,
  output logic            out_valid,
  input  wire logic       out_ready,
  output logic [7:0]      out_data,
  output logic            full
);
  logic [7:0] mem_r [2];
  logic       wr_r;
  logic       rd_r;
  logic [1:0] cnt_r;
  logic       push;
  logic       pop;

  assign in_ready  = (cnt_r != 2'd2);
  assign out_valid = (cnt_r != 2'd0);
  assign full      = (cnt_r == 2'd2);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_r[rd_r];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_r[0] <= 8'h00;
      mem_r[1] <= 8'h00;
    end else if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_r  <= 1'b0;
      rd_r  <= 1'b0;
      cnt_r <= 2'd0;
    end else begin
      if (push) wr_r <= ~wr_r;
      if (pop) rd_r <= ~rd_r;
      if (push && !pop) cnt_r <= cnt_r + 2'd1;
      else if (pop && !push) cnt_r <= cnt_r - 2'd1;
    end
  end
endmodule : ssp_buf2

// File: ssp_regs.sv
`timescale 1ns/100ps
module ssp_regs (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sck_in,
  input  wire logic        sdi_in,
  input  wire logic        ss_n_in,
  output logic             sck_out,
  output logic             sck_oe_n,
  output logic             sdo_out,
  input  wire logic        addr_byte_valid,
  input  wire logic [7:0]  addr_byte,
  input  wire logic        addr_high_phase,
  output logic             addr_match
);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] status_r;
  logic [7:0] reload_r;
  logic [7:0] mask_r;
  logic [7:0] control_r;
  logic [7:0] tx_r;
  logic       tx_pend_r;
  logic       wr_en;
  logic       rd_en;
  logic       mapped;
  ssp_pkg::ssp_mode_t mode;
  logic       enable;
  logic       master;
  logic       cke;
  logic       input_sample_phase;
  logic       idle_lvl;

  assign mode     = ssp_pkg::ssp_mode_t'(control_r[ssp_pkg::CTRL_MODE_LSB +: ssp_pkg::CTRL_MODE_W]);
  assign enable   = control_r[ssp_pkg::CTRL_ENABLE_BIT];
  assign master   = (mode == ssp_pkg::SSP_SPI_MASTER) || (mode == ssp_pkg::SSP_I2C_MASTER);
  assign cke      = status_r[ssp_pkg::STAT_EDGE_BIT];
  assign input_sample_phase      = status_r[ssp_pkg::STAT_SAMPLE_BIT];
  assign idle_lvl = control_r[ssp_pkg::CTRL_IDLE_BIT];

  // ------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------
  assign pready  = 1'b1;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign mapped  = (paddr == ssp_pkg::ADDR_STATUS) || (paddr == ssp_pkg::ADDR_RELOAD) ||
                   (paddr == ssp_pkg::ADDR_MASK) || (paddr == ssp_pkg::ADDR_CONTROL) ||
                   (paddr == ssp_pkg::ADDR_RXDATA) || (paddr == ssp_pkg::ADDR_TXDATA);
  assign pslverr = psel & penable & ~mapped;

  // buffer wiring
  logic       rx_push;
  logic       rx_in_ready;
  logic [7:0] rx_shift_r;
  logic       rx_valid;
  logic [7:0] rx_data;
  logic       rx_pop;

  assign rx_pop = rd_en && (paddr == ssp_pkg::ADDR_RXDATA);

  logic [7:0] status_rd;
  always_comb begin
    status_rd = {status_r[7:6], 5'h00, rx_valid};
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        ssp_pkg::ADDR_STATUS:  prdata <= {24'h000000, status_rd};
        ssp_pkg::ADDR_RELOAD:  prdata <= {24'h000000, reload_r};
        ssp_pkg::ADDR_MASK:    prdata <= {24'h000000, mask_r};
        ssp_pkg::ADDR_CONTROL: prdata <= {24'h000000, control_r};
        ssp_pkg::ADDR_RXDATA:  prdata <= {24'h000000, rx_data};
        ssp_pkg::ADDR_TXDATA:  prdata <= {24'h000000, tx_r};
        default:               prdata <= 32'h0000_0000;
      endcase
    end
  end

  // only the low byte is stored, so upper-byte writes vanish
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_r  <= ssp_pkg::RST_STATUS;
      reload_r  <= ssp_pkg::RST_RELOAD;
      mask_r    <= ssp_pkg::RST_MASK;
      control_r <= ssp_pkg::RST_CONTROL;
    end else begin
      if (wr_en && paddr == ssp_pkg::ADDR_STATUS) begin
        status_r <= {pwdata[7:6], 6'h00};
      end
      if (wr_en && paddr == ssp_pkg::ADDR_RELOAD) reload_r <= pwdata[7:0];
      if (wr_en && paddr == ssp_pkg::ADDR_MASK) mask_r <= pwdata[7:0];
      if (wr_en && paddr == ssp_pkg::ADDR_CONTROL) control_r <= pwdata[7:0];
      if (mode == ssp_pkg::SSP_SPI_SLAVE) status_r[ssp_pkg::STAT_SAMPLE_BIT] <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [ssp_pkg::SYNC_DEPTH-1:0] sck_s_r;
  logic [ssp_pkg::SYNC_DEPTH-1:0] sdi_s_r;
  logic [ssp_pkg::SYNC_DEPTH-1:0] ss_s_r;
  logic sck_q_r;
  logic sdi_q_r;
  logic ss_n_q_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_s_r  <= '0;
      sdi_s_r  <= '0;
      ss_s_r   <= '1;
      sck_q_r  <= 1'b0;
      sdi_q_r  <= 1'b0;
      ss_n_q_r <= 1'b1;
    end else begin
      sck_s_r <= {sck_s_r[1:0], sck_in};
      sdi_s_r <= {sdi_s_r[1:0], sdi_in};
      ss_s_r  <= {ss_s_r[1:0], ss_n_in};
      // a change counts only once stages two and three agree
      if (sck_s_r[1] == sck_s_r[2]) sck_q_r <= sck_s_r[2];
      if (sdi_s_r[1] == sdi_s_r[2]) sdi_q_r <= sdi_s_r[2];
      if (ss_s_r[1] == ss_s_r[2]) ss_n_q_r <= ss_s_r[2];
    end
  end

  // ------------------------------------------------------------
  // baud generator and master clock
  // ------------------------------------------------------------
  logic [7:0] baud_cnt_r;
  logic       half_tick;
  logic       sck_gen_r;
  logic [3:0] edge_cnt_r;
  logic       busy_r;

  assign half_tick = (baud_cnt_r == 8'h00);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      baud_cnt_r <= 8'h00;
    end else if (!busy_r || half_tick) begin
      baud_cnt_r <= reload_r;
    end else begin
      baud_cnt_r <= baud_cnt_r - 8'h01;
    end
  end

  // ------------------------------------------------------------
  // spi shifter: master edges from generator, slave from pin
  // ------------------------------------------------------------
  logic sck_prev_r;
  logic act_edge;
  logic idle_edge;
  logic sck_now;
  logic shift_edge;
  logic samp_edge;
  logic [7:0] tx_sh_r;
  logic [2:0] bit_cnt_r;
  logic       busy_d_r;
  logic       sck_live;
  logic       first_hold;

  assign sck_now   = master ? sck_gen_r : sck_q_r;
  assign act_edge  = (sck_now != sck_prev_r) && (sck_now != idle_lvl);
  assign idle_edge = (sck_now != sck_prev_r) && (sck_now == idle_lvl);
  assign shift_edge = cke ? idle_edge : act_edge;
  // end-of-time sampling waits for the next output edge
  assign samp_edge = (master && input_sample_phase) ? shift_edge : (cke ? act_edge : idle_edge);
  // last master edge is seen a cycle after busy drops, so the delayed copy keeps it live
  assign sck_live   = master ? (busy_r || busy_d_r) : !ss_n_q_r;
  // first leading edge drives the msb already shown; end sampling keeps the old order to line up
  assign first_hold = !cke && !(master && input_sample_phase) && (bit_cnt_r == 3'd0);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_gen_r  <= 1'b0;
      edge_cnt_r <= 4'h0;
      busy_r     <= 1'b0;
      sck_prev_r <= 1'b0;
      tx_sh_r    <= 8'h00;
      bit_cnt_r  <= 3'd0;
      rx_shift_r <= 8'h00;
      rx_push    <= 1'b0;
      tx_pend_r  <= 1'b0;
      tx_r       <= 8'h00;
      busy_d_r   <= 1'b0;
    end else begin
      sck_prev_r <= sck_now;
      busy_d_r   <= busy_r;
      rx_push    <= 1'b0;
      if (wr_en && paddr == ssp_pkg::ADDR_TXDATA) begin
        tx_r      <= pwdata[7:0];
        tx_pend_r <= 1'b1;
      end
      if (!busy_r) sck_gen_r <= idle_lvl;
      if (enable && master && !busy_r && !busy_d_r && tx_pend_r && rx_in_ready) begin
        busy_r     <= 1'b1;
        edge_cnt_r <= 4'h0;
        tx_sh_r    <= tx_r;
        tx_pend_r  <= 1'b0;
        bit_cnt_r  <= 3'd0;
      end else if (busy_r && half_tick) begin
        sck_gen_r  <= ~sck_gen_r;
        edge_cnt_r <= edge_cnt_r + 4'h1;
        if (edge_cnt_r == 4'hf) busy_r <= 1'b0;
      end
      if (enable && !master && ss_n_q_r) begin
        bit_cnt_r <= 3'd0;
        tx_sh_r   <= tx_r;
      end
      if (enable && samp_edge && sck_live) begin
        rx_shift_r <= {rx_shift_r[6:0], sdi_q_r};
        bit_cnt_r  <= bit_cnt_r + 3'd1;
        if (bit_cnt_r == 3'd7) rx_push <= 1'b1;
      end
      if (enable && shift_edge && sck_live && !first_hold) begin
        tx_sh_r <= {tx_sh_r[6:0], 1'b0};
      end
    end
  end

  assign sck_out  = sck_gen_r;
  assign sck_oe_n = ~(enable && master);
  assign sdo_out  = tx_sh_r[7];

  ssp_buf2 u_rx_buf (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  ({rx_push}),
    .in_ready  (rx_in_ready),
    .in_data   (rx_shift_r),
    .out_valid (rx_valid),
    .out_ready (rx_pop),
    .out_data  (rx_data),
    .full      ()
  );

  // ------------------------------------------------------------
  // i2c slave address match
  // ------------------------------------------------------------
  logic [7:0] care;
  logic [7:0] diff;
  always_comb begin
    diff = (addr_byte ^ reload_r) & ~mask_r;
    care = 8'hff;
    if (!control_r[ssp_pkg::CTRL_ADDR10_BIT]) begin
      care = 8'hfe;
    end else if (addr_high_phase) begin
      care = 8'h06;
    end
    // low phase keeps all eight bits
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_match <= 1'b0;
    end else if (addr_byte_valid) begin
      addr_match <= enable && (mode == ssp_pkg::SSP_I2C_SLAVE) && ((diff & care) == 8'h00) &&
                    (!control_r[ssp_pkg::CTRL_ADDR10_BIT] || !addr_high_phase ||
                     addr_byte[7:3] == ssp_pkg::TEN_BIT_HDR);
    end
  end
endmodule : ssp_regs

// File: ssp_regs_checker.sv
`timescale 1ns/100ps
module ssp_regs_checker (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sck_out,
  input wire logic        sck_oe_n,
  input wire logic        addr_byte_valid,
  input wire logic [7:0]  addr_byte,
  input wire logic        addr_high_phase,
  input wire logic        addr_match
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ------------------------------------------------------------
  // shadow of software writes
  // ------------------------------------------------------------
  logic [7:0] rld_r;
  logic [1:0] mode_r;
  logic [7:0] cnt_r;
  wire        acc    = psel & penable;
  wire        wr     = acc & pwrite & pready;
  wire        mapped = (paddr[11:2] < 10'h006) && (paddr[1:0] == 2'b00);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) rld_r <= 8'h00;
    else if (wr && paddr == ssp_pkg::ADDR_RELOAD) rld_r <= pwdata[7:0];
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) mode_r <= 2'b00;
    else if (wr && paddr == ssp_pkg::ADDR_CONTROL) mode_r <= pwdata[2:1];
  end
  // saturates so a long idle never wraps into a false short half period
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) cnt_r <= 8'hff;
    else if ($changed(sck_out)) cnt_r <= 8'h00;
    else if (cnt_r != 8'hff) cnt_r <= cnt_r + 8'h01;
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  a_pready_high: assert property (psel |-> pready) else $error("pready low");
  a_err_unmapped: assert property (acc && !mapped |-> pslverr) else $error("no error on unmapped address");
  a_err_mapped: assert property (acc && mapped |-> !pslverr) else $error("error on mapped address");
  a_upper_zero:
    assert property (acc && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits not zero");
  a_unmapped_zero: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0) else $error("unmapped read nonzero");
  a_slave_sample:
    assert property (acc && !pwrite && paddr == ssp_pkg::ADDR_STATUS && mode_r == 2'b01 |-> !prdata[7])
      else $error("sample bit set in slave mode");
  a_match_cause:
    assert property (!$stable(addr_match) |-> $past(addr_byte_valid)) else $error("match moved without byte");
  a_hdr_reject:
    assert property (addr_byte_valid && addr_high_phase && addr_byte[7:3] != ssp_pkg::TEN_BIT_HDR |=> !addr_match)
      else $error("bad header matched");
  a_half_min:
    assert property ($changed(sck_out) && !sck_oe_n && $past(!sck_oe_n) |-> cnt_r >= rld_r)
      else $error("serial clock half period short");
  c_match: cover property ($rose(addr_match));
  c_sck: cover property (!sck_oe_n && $changed(sck_out));
  c_slverr: cover property (acc && pslverr);
endmodule : ssp_regs_checker

bind ssp_regs ssp_regs_checker i_ssp_regs_checker (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sck_out(sck_out), .sck_oe_n(sck_oe_n), .addr_byte_valid(addr_byte_valid), .addr_byte(addr_byte),
  .addr_high_phase(addr_high_phase), .addr_match(addr_match));

// File: ssp_spi_peer.sv
`timescale 1ns/100ps
module ssp_spi_peer (
  input  wire logic oe_n,
  input  wire logic sdo,
  output logic      sdi
);
  // echo peer; when the port does not drive the clock, show the inverse so a stale bit never reads as good
  assign sdi = oe_n ? ~sdo : sdo;
endmodule : ssp_spi_peer

// File: ssp_regs_tb.sv
`timescale 1ns/100ps
module ssp_regs_tb;
  logic        clk, reset_n, psel, penable, pwrite, sdi_in, sck_in, ss_n_in, pready, pslverr;
  logic        sck_out, sck_oe_n, sdo_out, addr_byte_valid, addr_high_phase, addr_match, v_d, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  addr_byte, rl, mk, b;
  logic [7:0]  tx[3];
  logic [7:0]  rq[$];
  logic        mq[$];
  int          err_total, n_compared, ph;
  ssp_regs i_ssp_regs (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_in(sck_in),
    .sdi_in(sdi_in), .ss_n_in(ss_n_in), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .sdo_out(sdo_out),
    .addr_byte_valid(addr_byte_valid), .addr_byte(addr_byte), .addr_high_phase(addr_high_phase),
    .addr_match(addr_match));
  ssp_spi_peer i_ssp_spi_peer (.oe_n(sck_oe_n), .sdo(sdo_out), .sdi(sdi_in));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    rq.push_back(x);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic ab(input logic [7:0] v, input logic hi, input logic x);
    addr_byte_valid <= 1'b1;
    addr_byte <= v;
    addr_high_phase <= hi;
    mq.push_back(x);
    @(posedge clk);
    addr_byte_valid <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : ab
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  // ------------------------------------------------------------
  // monitor: oldest note against each result
  // ------------------------------------------------------------
  always @(posedge clk) begin
    v_d <= addr_byte_valid;
    if (psel && penable && !pwrite && pready) chk(prdata, {24'h0, rq.pop_front()});
    if (v_d) chk({31'h0, addr_match}, {31'h0, mq.pop_front()});
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    results();
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, addr_byte_valid, addr_high_phase} = 5'h00;
    {sck_in, ss_n_in} = 2'b01;
    paddr = 12'h000;
    pwdata = 32'h0;
    addr_byte = 8'h00;
    reset_n = 1'b0;
    void'($urandom(32'h9ee7));
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(ssp_pkg::ADDR_STATUS, ssp_pkg::RST_STATUS);
    rd(ssp_pkg::ADDR_RELOAD, ssp_pkg::RST_RELOAD);
    rd(ssp_pkg::ADDR_MASK, ssp_pkg::RST_MASK);
    rl = 8'($urandom);
    apb(1'b1, ssp_pkg::ADDR_RELOAD, {24'hffffff, rl});
    rd(ssp_pkg::ADDR_RELOAD, rl);
    rd(12'h040, 8'h00);
    apb(1'b1, ssp_pkg::ADDR_CONTROL, 32'h3);
    apb(1'b1, ssp_pkg::ADDR_STATUS, 32'hc0);
    rd(ssp_pkg::ADDR_STATUS, 8'h40);
    $display("test registers done");
    apb(1'b1, ssp_pkg::ADDR_CONTROL, 32'h1);
    apb(1'b1, ssp_pkg::ADDR_STATUS, 32'h0);
    apb(1'b1, ssp_pkg::ADDR_RELOAD, 32'h7);
    // third byte must wait on the full buffer, not overwrite it
    for (int k = 0; k < 3; k++) begin
      tx[k] = 8'($urandom);
      apb(1'b1, ssp_pkg::ADDR_TXDATA, {24'h0, tx[k]});
      repeat (200) @(posedge clk);
    end
    rd(ssp_pkg::ADDR_STATUS, 8'h01);
    rd(ssp_pkg::ADDR_RXDATA, tx[0]);
    rd(ssp_pkg::ADDR_RXDATA, tx[1]);
    repeat (200) @(posedge clk);
    rd(ssp_pkg::ADDR_RXDATA, tx[2]);
    rd(ssp_pkg::ADDR_STATUS, 8'h00);
    $display("test transfer done");
    // master, idle high, output on active-to-idle, end sampling
    apb(1'b1, ssp_pkg::ADDR_CONTROL, 32'h11);
    apb(1'b1, ssp_pkg::ADDR_STATUS, 32'hc0);
    rd(ssp_pkg::ADDR_STATUS, 8'hc0);
    tx[0] = 8'($urandom);
    apb(1'b1, ssp_pkg::ADDR_TXDATA, {24'h0, tx[0]});
    repeat (200) @(posedge clk);
    rd(ssp_pkg::ADDR_RXDATA, tx[0]);
    // slave frame: peer shows the inverse while the port does not drive the clock
    apb(1'b1, ssp_pkg::ADDR_CONTROL, 32'h3);
    apb(1'b1, ssp_pkg::ADDR_STATUS, 32'h0);
    tx[1] = 8'($urandom);
    apb(1'b1, ssp_pkg::ADDR_TXDATA, {24'h0, tx[1]});
    ss_n_in <= 1'b0;
    repeat (10) @(posedge clk);
    repeat (8) begin
      sck_in <= 1'b1;
      repeat (10) @(posedge clk);
      sck_in <= 1'b0;
      repeat (10) @(posedge clk);
    end
    ss_n_in <= 1'b1;
    repeat (10) @(posedge clk);
    rd(ssp_pkg::ADDR_RXDATA, ~tx[1]);
    $display("test clock edges done");
    for (int i = 0; i < 24; i++) begin
      ph = i % 3;
      rl = 8'($urandom);
      mk = 8'($urandom);
      if (ph == 2) rl[7:3] = ssp_pkg::TEN_BIT_HDR;
      b = i[0] ? 8'($urandom) : rl ^ (8'($urandom) & mk);
      apb(1'b1, ssp_pkg::ADDR_CONTROL, (ph != 0) ? 32'hf : 32'h7);
      apb(1'b1, ssp_pkg::ADDR_RELOAD, {24'h0, rl});
      apb(1'b1, ssp_pkg::ADDR_MASK, {24'h0, mk});
      case (ph)
        0: e = ((b ^ rl) & ~mk & 8'hfe) == 8'h00;
        1: e = ((b ^ rl) & ~mk) == 8'h00;
        default: e = (b[7:3] == ssp_pkg::TEN_BIT_HDR) && (((b ^ rl) & ~mk & 8'h06) == 8'h00);
      endcase
      ab(b, ph == 2, e);
    end
    $display("test address match done");
    results();
  end
endmodule : ssp_regs_tb
